/* core/wmu_watch_unit.sv */
// Function
// RL1: A watch exception is taken on a hit only while both the exception and error level bits are zero.
// RL2: A hit while either level bit is one sets the pending flag and defers the exception until both clear.
// RL3: Virtual address bits 31 to 3 are compared with the stored address, covering an aligned doubleword.
// RL4: Address bit 2 enables fetch hits and is cleared by cold reset only.
// RL5: Address bit 1 enables load hits and is cleared by cold reset only.
// RL6: Address bit 0 enables store hits and is cleared by cold reset only.
// RL7: With the global bit set, a hit ignores the address-space tag.
// RL8: With the global bit clear, the qualifier tag must equal the current address-space tag.
// RL9: Each set mask bit removes its address bit from the compare.
// RL10: Qualifier bits 31, 29 to 24, 15 to 12 and 2 to 0 read as zero; software writes zeros there.
// RL11: Address, global, tag and mask fields hold no defined value until software programs them.
// RL12: The exception is raised on the matching access before it completes, with the watch code.
`include "wmu_defines.svh"

module wmu_watch_unit #(
  // Field widths of the match registers
  parameter int MATCH_WIDTH = 29,
  parameter int TAG_WIDTH = 8,
  parameter int MASK_WIDTH = 9
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic warm_rst_n,
  // Register access from the system coprocessor
  input wire wmu_pkg::wmu_regport_type regport,
  output logic [31:0] rd_data_ff,
  // Processor state
  input wire wmu_pkg::wmu_status_type status,
  input wire logic [TAG_WIDTH-1:0] address_space_tag,
  input wire logic pending_clear,
  // Access from the pipeline
  input wire wmu_pkg::wmu_req_type req,
  // Exception outputs
  output logic watch_exc_ff,
  output logic [4:0] exc_code_ff,
  output logic watch_pending_ff
);

  // ****************************************
  // Field geometry
  // ****************************************
  // The field widths follow from the bit positions in the header. A field that changes width, or an
  // overridden width that the fixed register layout cannot hold, stops elaboration here.
  localparam int ADDR_FIELD_W = `WMU_ADDR_HI - `WMU_ADDR_LO + 1;
  localparam int TAG_FIELD_W = `WMU_TAG_HI - `WMU_TAG_LO + 1;
  localparam int MASK_FIELD_W = `WMU_MASK_HI - `WMU_MASK_LO + 1;

  if (MATCH_WIDTH != ADDR_FIELD_W) begin : g_bad_match_width
    $error("Match width does not fit the address field.");
  end

  if (TAG_WIDTH != TAG_FIELD_W) begin : g_bad_tag_width
    $error("Tag width does not fit the tag field.");
  end

  if (MASK_WIDTH != MASK_FIELD_W) begin : g_bad_mask_width
    $error("Mask width does not fit the mask field.");
  end

  // The comparator lines mask bit 0 up with the lowest compared address bit.
  if (`WMU_MASK_LO != `WMU_ADDR_LO) begin : g_bad_mask_base
    $error("Mask field does not start at the lowest compared address bit.");
  end

  // The enables share the word with the address, below its lowest bit.
  if (`WMU_EN_FETCH_BIT >= `WMU_ADDR_LO) begin : g_bad_enable_pos
    $error("Enable bits overlap the match address field.");
  end

  // The global bit must sit apart from the tag, and the tag apart from the mask.
  if (`WMU_GLOBAL_BIT <= `WMU_TAG_HI) begin : g_bad_global_pos
    $error("Global bit overlaps the tag field.");
  end

  if (`WMU_TAG_LO <= `WMU_MASK_HI) begin : g_bad_tag_pos
    $error("Tag field overlaps the mask field.");
  end

  // An idle code equal to the watch code would make every cycle look like a hit.
  if (`WMU_WATCH_CODE == `WMU_NO_CODE) begin : g_bad_codes
    $error("Watch code must differ from the idle code.");
  end

  // ****************************************
  // Register state
  // ****************************************
  logic [MATCH_WIDTH-1:0] addr_ff;
  logic [MATCH_WIDTH-1:0] nxt_addr;
  logic [2:0] enable_ff;
  logic [2:0] nxt_enable;
  logic global_ff;
  logic nxt_global;
  logic [TAG_WIDTH-1:0] tag_ff;
  logic [TAG_WIDTH-1:0] nxt_tag;
  logic [MASK_WIDTH-1:0] mask_ff;
  logic [MASK_WIDTH-1:0] nxt_mask;
  logic [31:0] nxt_rd_data;

  // ****************************************
  // Register decode
  // ****************************************
  logic wr_address;
  logic wr_qualifier;
  logic rd_address;
  logic rd_qualifier;

  // One strobe qualified by one select; shared by the four register strobes.
  function automatic logic strobe_for(
    input logic strobe,
    input logic sel,
    input logic want
  );
    return strobe && (sel == want);
  endfunction : strobe_for

  always_comb begin
    wr_address = strobe_for(regport.wr_en, regport.sel, `WMU_SEL_ADDRESS);
    wr_qualifier = strobe_for(regport.wr_en, regport.sel, `WMU_SEL_QUALIFIER);
    rd_address = strobe_for(regport.rd_en, regport.sel, `WMU_SEL_ADDRESS);
    rd_qualifier = strobe_for(regport.rd_en, regport.sel, `WMU_SEL_QUALIFIER);
  end

  // ****************************************
  // Read word assembly
  // ****************************************
  function automatic logic [31:0] address_word(
    input logic [MATCH_WIDTH-1:0] a,
    input logic [2:0] e
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`WMU_ADDR_HI:`WMU_ADDR_LO] = a;
    w[`WMU_EN_FETCH_BIT] = e[`WMU_EN_FETCH_BIT];
    w[`WMU_EN_LOAD_BIT] = e[`WMU_EN_LOAD_BIT];
    w[`WMU_EN_STORE_BIT] = e[`WMU_EN_STORE_BIT];
    return w;
  endfunction : address_word

  function automatic logic [31:0] qualifier_word(
    input logic g,
    input logic [TAG_WIDTH-1:0] t,
    input logic [MASK_WIDTH-1:0] m
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`WMU_GLOBAL_BIT] = g;
    w[`WMU_TAG_HI:`WMU_TAG_LO] = t;
    w[`WMU_MASK_HI:`WMU_MASK_LO] = m;
    return w;
  endfunction : qualifier_word

  // ****************************************
  // Match address group
  // ****************************************
  always_comb begin
    nxt_addr = addr_ff;
    nxt_enable = enable_ff;
    if (wr_address) begin
      nxt_addr = regport.wdata[`WMU_ADDR_HI:`WMU_ADDR_LO];
      // RL4 fetch enable
      nxt_enable[`WMU_EN_FETCH_BIT] = regport.wdata[`WMU_EN_FETCH_BIT];
      // RL5 load enable
      nxt_enable[`WMU_EN_LOAD_BIT] = regport.wdata[`WMU_EN_LOAD_BIT];
      // RL6 store enable
      nxt_enable[`WMU_EN_STORE_BIT] = regport.wdata[`WMU_EN_STORE_BIT];
    end
  end

  // Only rst_n is the cold reset; a warm reset leaves the enables alone.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // RL4 cold reset clears
      enable_ff <= `WMU_EN_RESET;
      // RL11 zeroed for simulation only
      addr_ff <= MATCH_WIDTH'(`WMU_FIELD_RESET);
    end else begin
      enable_ff <= nxt_enable;
      addr_ff <= nxt_addr;
    end
  end

  // ****************************************
  // Qualifier group
  // ****************************************
  always_comb begin
    nxt_global = global_ff;
    nxt_tag = tag_ff;
    nxt_mask = mask_ff;
    if (wr_qualifier) begin
      // RL10 reserved bits dropped
      nxt_global = regport.wdata[`WMU_GLOBAL_BIT];
      nxt_tag = regport.wdata[`WMU_TAG_HI:`WMU_TAG_LO];
      nxt_mask = regport.wdata[`WMU_MASK_HI:`WMU_MASK_LO];
    end
  end

  // Software must program these before it sets an enable; the reset value is no promise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // RL11 zeroed for simulation only
      global_ff <= 1'b0;
      tag_ff <= TAG_WIDTH'(`WMU_FIELD_RESET);
      mask_ff <= MASK_WIDTH'(`WMU_FIELD_RESET);
    end else begin
      global_ff <= nxt_global;
      tag_ff <= nxt_tag;
      mask_ff <= nxt_mask;
    end
  end

  // ****************************************
  // Read data group
  // ****************************************
  always_comb begin
    nxt_rd_data = rd_data_ff;
    // A read in the same cycle as a write returns the old contents.
    if (rd_address) begin
      nxt_rd_data = address_word(addr_ff, enable_ff);
    end
    if (rd_qualifier) begin
      // RL10 reserved bits read zero
      nxt_rd_data = qualifier_word(global_ff, tag_ff, mask_ff);
    end
  end

  // Read data holds until the next read, so software may sample it late.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_ff <= `WMU_FIELD_RESET;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // ****************************************
  // Match and exception logic
  // ****************************************
  logic addr_hit;
  logic kind_enabled;
  logic hit;
  logic level_clear;
  logic nxt_exc;
  logic [4:0] nxt_code;
  logic nxt_pending;

  // The exception leaves a flip-flop, so the pipeline holds the matching access one
  // cycle longer; that costs a stall on a hit but keeps the exception precise.
  wmu_addr_cmp u_cmp (
    .match_addr(addr_ff),
    .match_mask(mask_ff),
    .global_bit(global_ff),
    .match_tag(tag_ff),
    .match_field_a(req.match_field_a),
    .address_space_tag(address_space_tag),
    .hit(addr_hit)
  );

  always_comb begin
    unique case (req.kind)
      // RL4 fetch type
      wmu_pkg::WMU_ACC_FETCH: kind_enabled = enable_ff[`WMU_EN_FETCH_BIT];
      // RL5 load type
      wmu_pkg::WMU_ACC_LOAD: kind_enabled = enable_ff[`WMU_EN_LOAD_BIT];
      // RL6 store type
      wmu_pkg::WMU_ACC_STORE: kind_enabled = enable_ff[`WMU_EN_STORE_BIT];
      default: kind_enabled = 1'b0;
    endcase
    hit = req.valid && kind_enabled && addr_hit;
    level_clear = !status.exception_level_bit && !status.error_level_bit;
    nxt_exc = 1'b0;
    nxt_pending = watch_pending_ff;
    if (pending_clear) begin
      nxt_pending = 1'b0;
    end
    if (level_clear) begin
      // RL1 take when levels clear
      // RL2 deferred hit taken now
      if (hit || watch_pending_ff) begin
        nxt_exc = 1'b1;
        nxt_pending = 1'b0;
      end
    end else if (hit) begin
      // RL2 hold as pending, set wins
      nxt_pending = 1'b1;
    end
    // RL12 report watch code
    nxt_code = nxt_exc ? `WMU_WATCH_CODE : `WMU_NO_CODE;
  end

  // A warm reset drops a held hit so no stale exception follows it.
  always_ff @(posedge clk) begin
    if (!rst_n || !warm_rst_n) begin
      watch_exc_ff <= 1'b0;
      exc_code_ff <= `WMU_NO_CODE;
      watch_pending_ff <= 1'b0;
    end else begin
      // RL12 flag before completion
      watch_exc_ff <= nxt_exc;
      exc_code_ff <= nxt_code;
      watch_pending_ff <= nxt_pending;
    end
  end

endmodule : wmu_watch_unit

/* core/wmu_defines.svh */
`ifndef WMU_DEFINES_SVH
`define WMU_DEFINES_SVH

// ****************************************
// Register selects on the system coprocessor port
// ****************************************
`define WMU_SEL_ADDRESS 1'h0
`define WMU_SEL_QUALIFIER 1'h1

// ****************************************
// Match address register fields
// ****************************************
`define WMU_ADDR_HI 31
`define WMU_ADDR_LO 3
`define WMU_EN_FETCH_BIT 2
`define WMU_EN_LOAD_BIT 1
`define WMU_EN_STORE_BIT 0

// ****************************************
// Qualifier register fields
// ****************************************
`define WMU_GLOBAL_BIT 30
`define WMU_TAG_HI 23
`define WMU_TAG_LO 16
`define WMU_MASK_HI 11
`define WMU_MASK_LO 3

// ****************************************
// Reset values and codes
// ****************************************
`define WMU_EN_RESET 3'h0
`define WMU_FIELD_RESET 32'h0000_0000
`define WMU_WATCH_CODE 5'h17
`define WMU_NO_CODE 5'h00

`endif

/* core/wmu_pkg.sv */
package wmu_pkg;

  // ****************************************
  // Access kinds presented by the pipeline
  // ****************************************
  typedef enum logic [1:0] {
    WMU_ACC_FETCH = 2'b00,
    WMU_ACC_LOAD = 2'b01,
    WMU_ACC_STORE = 2'b10
  } wmu_access_type;

  typedef struct packed {
    logic valid;
    wmu_access_type kind;
    logic [31:0] match_field_a;
  } wmu_req_type;

  typedef struct packed {
    logic exception_level_bit;
    logic error_level_bit;
  } wmu_status_type;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic sel;
    logic [31:0] wdata;
  } wmu_regport_type;

endpackage : wmu_pkg

/* core/wmu_addr_cmp.sv */
`include "wmu_defines.svh"

module wmu_addr_cmp (
  // Stored match fields
  input wire logic [28:0] match_addr,
  input wire logic [8:0] match_mask,
  input wire logic global_bit,
  input wire logic [7:0] match_tag,
  // Current access
  input wire logic [31:0] match_field_a,
  input wire logic [7:0] address_space_tag,
  // Result
  output logic hit
);

  logic [28:0] diff;
  logic [28:0] care;

  always_comb begin
    // RL3 doubleword compare
    diff = match_field_a[`WMU_ADDR_HI:`WMU_ADDR_LO] ^ match_addr;
    // RL9 mask excludes bits
    care = {20'hf_ffff, ~match_mask};
    // RL7 global ignores tag
    // RL8 tag must match
    hit = ((diff & care) == 29'h0000_0000) && (global_bit || (match_tag == address_space_tag));
  end

endmodule : wmu_addr_cmp

/* verification/wmu_pipe_model.sv */
// ********
// Pipeline access source
// ********
module wmu_pipe_model (
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic go,
  input wire wmu_pkg::wmu_access_type kind,
  input wire logic [31:0] match_field_a,
  // Access to the unit
  output wmu_pkg::wmu_req_type req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] last_ff;
  initial last_ff = 32'h0000_0000;
  // Idle cycles toggle the address, so every second idle cycle repeats the stale access; only the low valid keeps it from a match.
  always @(posedge clk) last_ff <= req.match_field_a;
  assign req = '{valid: go, kind: kind, match_field_a: go ? match_field_a : ~last_ff};
endmodule : wmu_pipe_model

/* verification/wmu_watch_monitor.sv */
// ********
// Watch unit checker
// ********
module wmu_watch_monitor (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic warm_rst_n,
  // Inputs
  input wire wmu_pkg::wmu_regport_type regport,
  input wire wmu_pkg::wmu_status_type status,
  input wire logic [7:0] address_space_tag,
  input wire logic pending_clear,
  input wire wmu_pkg::wmu_req_type req,
  // Outputs
  input wire logic [31:0] rd_data_ff,
  input wire logic watch_exc_ff,
  input wire logic [4:0] exc_code_ff,
  input wire logic watch_pending_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic lvl;
  assign lvl = status.exception_level_bit | status.error_level_bit;
  sequence s_held;
    watch_pending_ff && !pending_clear && warm_rst_n;
  endsequence
  a_code_match: assert property (exc_code_ff == (watch_exc_ff ? 5'h17 : 5'h00))
    else $error("bad code");
  a_exc_free_only: assert property (watch_exc_ff |-> !$past(lvl))
    else $error("exc at level");
  a_level_defers: assert property (lvl |=> !watch_exc_ff)
    else $error("not deferred");
  a_pend_holds: assert property (s_held ##0 lvl |=> watch_pending_ff)
    else $error("pend lost");
  a_pend_taken: assert property (s_held ##0 !lvl |=> watch_exc_ff && !watch_pending_ff)
    else $error("pend not taken");
  a_pend_clear: assert property (pending_clear && !req.valid |=> !watch_pending_ff)
    else $error("pend kept");
  a_warm_clears: assert property (!warm_rst_n |=> !watch_exc_ff && !watch_pending_ff)
    else $error("warm reset");
  a_no_cause: assert property (!req.valid && !watch_pending_ff |=> !watch_exc_ff)
    else $error("spurious exc");
  a_qual_zeros: assert property (regport.rd_en && regport.sel |=>
    (rd_data_ff & 32'hBF00_F007) == 32'h0000_0000) else $error("reserved set");
endmodule : wmu_watch_monitor

bind wmu_watch_unit wmu_watch_monitor mon (.clk(clk), .rst_n(rst_n), .warm_rst_n(warm_rst_n),
  .regport(regport), .status(status), .address_space_tag(address_space_tag),
  .pending_clear(pending_clear), .req(req), .rd_data_ff(rd_data_ff),
  .watch_exc_ff(watch_exc_ff), .exc_code_ff(exc_code_ff), .watch_pending_ff(watch_pending_ff));

/* verification/watch_match_unit_bench.sv */
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, a, b); end end
module watch_match_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, warm_rst_n = 1'b1, pending_clear = 1'b0, go = 1'b0, exc, pend;
  wmu_pkg::wmu_regport_type regport = '0;
  wmu_pkg::wmu_status_type status = '0;
  wmu_pkg::wmu_access_type k = wmu_pkg::WMU_ACC_FETCH;
  wmu_pkg::wmu_req_type req;
  logic [7:0] cur = 8'h00;
  logic [31:0] va = 32'h0000_0000, rd_data, a, q;
  logic [4:0] code;
  int mismatches = 0, samples_checked = 0, seed = 32'h4793;
  always #5 clk = ~clk;
  wmu_pipe_model pipe (.clk(clk), .go(go), .kind(k), .match_field_a(va), .req(req));
  wmu_watch_unit uut (.clk(clk), .rst_n(rst_n), .warm_rst_n(warm_rst_n), .regport(regport),
    .rd_data_ff(rd_data), .status(status), .address_space_tag(cur),
    .pending_clear(pending_clear), .req(req), .watch_exc_ff(exc), .exc_code_ff(code),
    .watch_pending_ff(pend));
  function automatic logic hit_of(input logic [31:0] a, q, v, input logic [7:0] c,
    input logic [1:0] k);
    return (((a[31:3] ^ v[31:3]) & ~{20'h0_0000, q[11:3]}) == 29'h0)
      && (q[30] || q[23:16] == c) && (k != 2'b11) && a[2 - k];
  endfunction : hit_of
  task automatic reg_op(input logic wr, input logic sel, input logic [31:0] d);
    @(negedge clk);
    regport = '{wr_en: wr, rd_en: !wr, sel: sel, wdata: d};
    @(negedge clk);
    regport = '0;
  endtask : reg_op
  task automatic access(input wmu_pkg::wmu_access_type kd, input logic [31:0] v);
    @(negedge clk);
    go = 1'b1;
    k = kd;
    va = v;
    @(negedge clk);
    go = 1'b0;
  endtask : access
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    reg_op(1'b1, 1'b1, 32'hFFFF_FFFF);
    reg_op(1'b0, 1'b1, 32'h0000_0000);
    `CHK(rd_data, 32'h40FF_0FF8)
    for (int i = 0; i < 60; i++) begin
      a = $random(seed);
      q = $random(seed) & 32'h40FF_0FF8;
      cur = i[0] ? q[23:16] : 8'($random(seed));
      reg_op(1'b1, 1'b0, a);
      reg_op(1'b1, 1'b1, q);
      reg_op(1'b0, 1'b0, 32'h0000_0000);
      `CHK(rd_data, a)
      access(wmu_pkg::wmu_access_type'(2'($random(seed))),
        a ^ ($random(seed) & (i % 5 ? 32'h0000_0FFF : 32'hFFFF_FFFF)));
      `CHK({exc, code}, hit_of(a, q, va, cur, k) ? 6'h37 : 6'h00)
    end
    reg_op(1'b1, 1'b0, 32'h1234_5606);
    reg_op(1'b1, 1'b1, 32'h4000_0000);
    status.exception_level_bit = 1'b1;
    access(wmu_pkg::WMU_ACC_LOAD, 32'h1234_5600);
    `CHK({exc, pend}, 2'h1)
    status = '0;
    @(negedge clk);
    `CHK({exc, pend, code}, 7'h57)
    status.error_level_bit = 1'b1;
    access(wmu_pkg::WMU_ACC_FETCH, 32'h1234_5604);
    @(negedge clk);
    `CHK({exc, pend}, 2'h1)
    pending_clear = 1'b1;
    @(negedge clk);
    pending_clear = 1'b0;
    status = '0;
    @(negedge clk);
    `CHK({exc, pend}, 2'h0)
    status.error_level_bit = 1'b1;
    pending_clear = 1'b1;
    access(wmu_pkg::WMU_ACC_LOAD, 32'h1234_5600);
    pending_clear = 1'b0;
    `CHK({exc, pend}, 2'h1)
    warm_rst_n = 1'b0;
    reg_op(1'b0, 1'b0, 32'h0000_0000);
    warm_rst_n = 1'b1;
    status = '0;
    `CHK({exc, pend}, 2'h0)
    `CHK(rd_data, 32'h1234_5606)
    @(negedge clk);
    `CHK({exc, pend}, 2'h0)
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    reg_op(1'b0, 1'b0, 32'h0000_0000);
    `CHK(rd_data[2:0], 3'h0)
    tally_and_finish();
  end
endmodule : watch_match_unit_bench
